// ===== rtl/smart_log_pkg.sv
package smart_log_pkg;
    // time base
    localparam int CLK_HZ = 125_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYC_DEF = CLK_HZ / MS_PER_S;
    // sector layout
    localparam int SECT = 512;
    localparam logic [1:0] LOG_ERR = 2'h0;
    localparam logic [1:0] LOG_SELF = 2'h1;
    localparam logic [1:0] LOG_SEL = 2'h2;
    localparam int B_CSUM = 511;
    localparam int B_EPTR = 1;
    localparam int B_ECNT = 452;
    localparam int B_EBASE = 2;
    localparam int ERR_ENT_LEN = 90;
    localparam int CMD_LEN = 12;
    localparam int CMD_BYTES = 60;
    localparam int ERR_ST_LEN = 30;
    localparam int N_ERR = 5;
    localparam int B_STBASE = 2;
    localparam int ST_DESC_LEN = 24;
    localparam int N_ST = 21;
    localparam int B_STPTR = 508;
    localparam int B_SPAN_END = 81;
    localparam int B_PROG_LO = 492;
    localparam int B_PROG_HI = 501;
    localparam int B_FLAG_LO = 502;
    localparam int B_FLAG_HI = 503;
    localparam int B_PEND_LO = 508;
    localparam int B_PEND_HI = 509;
    // values after reset
    localparam logic [7:0] ERR_LOG_VER = 8'h01;
    localparam logic [7:0] ST_REV = 8'h01;
    localparam logic [7:0] SEL_REV = 8'h01;
    localparam logic HM_EN_RST = 1'b1;
    localparam logic [3:0] STATE_HI_NIB = 4'h0;
    // health command, key and subcommands
    localparam logic [7:0] HM_CMD = 8'hB0;
    localparam logic [7:0] KEY_MID = 8'h4F;
    localparam logic [7:0] KEY_HI = 8'hC2;
    localparam logic [7:0] SUB_RDVAL = 8'hD0;
    localparam logic [7:0] SUB_RDTHR = 8'hD1;
    localparam logic [7:0] SUB_WRVAL = 8'hD3;
    localparam logic [7:0] SUB_RDLOG = 8'hD5;
    localparam logic [7:0] SUB_WRLOG = 8'hD6;
    localparam logic [7:0] SUB_ENA = 8'hD8;
    localparam logic [7:0] SUB_DIS = 8'hD9;
    localparam logic [7:0] SUB_STAT = 8'hDA;
    // answers
    localparam logic [7:0] STS_OK = 8'h50;
    localparam logic [7:0] STS_FAIL = 8'h51;
    localparam logic [7:0] ER_NONE = 8'h00;
    localparam logic [7:0] ER_ABRT = 8'h04;
    localparam logic [7:0] ER_TBL_RD = 8'h10;
    localparam logic [7:0] ER_TBL_WR = 8'h40;
    localparam int STS_ERR_BIT = 0;
    // register map (byte addresses)
    localparam logic [11:0] A_CTRL = 12'h600;
    localparam logic [11:0] A_STAT = 12'h604;
    localparam logic [11:0] A_MS = 12'h608;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ===== rtl/smart_log_recorder.sv
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
// Contract
// RULE1: command entry bytes 0-6 taskfile at command write, byte 7 command code.
// RULE2: command entry bytes 8-11 hold wrapping milliseconds since power-on.
// RULE3: error entry bytes 1-7 hold completion error..status values, byte 0 reserved.
// RULE4: error entry bytes 8-26 carry free extended error information.
// RULE5: error byte 27 low nibble is device state code at issue.
// RULE6: state byte upper nibble is implementation-defined.
// RULE7: error entry ends with lifetime stamp, low byte 28, high byte 29.
// RULE8: self-test log: revision at 0-1, 24-byte descriptors at n*24+2.
// RULE9: descriptor: number, status, lifetime stamp, checkpoint, four-byte failing LBA.
// RULE10: after 21 descriptors the newest overwrites the oldest.
// RULE11: self-test byte 508 indexes newest descriptor, 0 when empty.
// RULE12: byte 511 of each sector makes the sector sum to zero.
// RULE13: selective log host-readable and writable, five start/end spans.
// RULE14: current LBA and span under test are read-only progress fields.
// RULE15: feature flags and pending time are host-writable.
// RULE16: multi-byte fields stored least significant byte first.
// RULE17: missing key in LBA mid/high gives status 51h error 04h.
// RULE18: invalid subcommand aborts with status 51h error 04h.
// RULE19: while disabled, only enable subcommand accepted, else 51h/04h.
// RULE20: unreadable attribute tables give status 51h error 10h.
// RULE21: unwritable attribute table gives status 51h error 40h.
// RULE22: error log pointer names newest entry, only values 1 to 5; the pointer byte reads 0 after reset until the first error is logged.
// RULE23: device error count saturates instead of rolling over.
// RULE24: new error fills next entry circularly, then pointer moves there.
module smart_log_recorder
    import smart_log_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_tf_devctl,
    input wire logic [7:0] i_tf_feat,
    input wire logic [7:0] i_tf_count,
    input wire logic [7:0] i_tf_lba_lo,
    input wire logic [7:0] i_tf_lba_mid,
    input wire logic [7:0] i_tf_lba_hi,
    input wire logic [7:0] i_tf_dev,
    input wire logic [7:0] i_tf_cmd,
    input wire logic [3:0] i_dev_state,
    input wire logic i_cmp,
    input wire logic [7:0] i_cmp_error,
    input wire logic [7:0] i_cmp_count,
    input wire logic [7:0] i_cmp_lba_lo,
    input wire logic [7:0] i_cmp_lba_mid,
    input wire logic [7:0] i_cmp_lba_hi,
    input wire logic [7:0] i_cmp_dev,
    input wire logic [7:0] i_cmp_status,
    input wire logic [15:0] i_life,
    input wire logic i_st_done,
    input wire logic [7:0] i_st_num,
    input wire logic [7:0] i_st_stat,
    input wire logic [7:0] i_st_chk,
    input wire logic [31:0] i_st_lba,
    input wire logic [63:0] i_st_cur_lba,
    input wire logic [15:0] i_st_cur_span,
    input wire logic i_tbl_rd_fail,
    input wire logic i_tbl_wr_fail,
    output logic o_hm_done,
    output logic [7:0] o_hm_status,
    output logic [7:0] o_hm_error,
    output logic o_hm_en
);

typedef enum logic [2:0] {S_IDLE, S_ERR, S_EHDR, S_ST, S_SPTR, S_WBW} seq_e;

seq_e seq_r;
logic [6:0] k_r;
logic [7:0] mem [0:3*SECT-1];
logic [7:0] sum_r [0:2];
logic [7:0] hist [0:CMD_BYTES-1];
logic [7:0] errb [0:ERR_ST_LEN-1];
logic [7:0] stb [0:ST_DESC_LEN-1];
logic [2:0] hwp_r;
logic [3:0] dstate_r;
logic [31:0] pre_r;
logic [31:0] ms_r;
logic [2:0] eptr_r;
logic [15:0] ecnt_r;
logic [4:0] stp_r;
logic err_pend_r;
logic st_pend_r;
logic [79:0] prog_r;
logic ack_r;
logic [31:0] rdat_r;
logic hm_en_r;
logic hm_done_r;
logic [7:0] hm_sts_r;
logic [7:0] hm_err_r;
logic req;
logic sel_wr;
logic start_err;
logic start_st;
logic start_wbw;
logic err_evt;
logic we;
logic [10:0] wa;
logic [7:0] wd;
logic [7:0] prog_sum;
logic [31:0] rd_word;
int hb;

assign o_wb_dat = rdat_r;
assign o_wb_ack = ack_r;
assign o_hm_done = hm_done_r;
assign o_hm_status = hm_sts_r;
assign o_hm_error = hm_err_r;
assign o_hm_en = hm_en_r;
assign hb = int'(hwp_r) * CMD_LEN;

assign req = i_wb_cyc & i_wb_stb & ~ack_r;
assign sel_wr = req & i_wb_we & (i_wb_adr[11:9] == {1'b0, LOG_SEL});
assign err_evt = i_cmp & i_cmp_status[STS_ERR_BIT];
assign start_err = (seq_r == S_IDLE) & err_pend_r;
assign start_st = (seq_r == S_IDLE) & ~err_pend_r & st_pend_r;
// host writes wait behind logging so entries are never torn
assign start_wbw = (seq_r == S_IDLE) & ~err_pend_r & ~st_pend_r & sel_wr;

function automatic logic host_writable(input int b);
    host_writable = (b <= B_SPAN_END) || (b >= B_FLAG_LO && b <= B_FLAG_HI) ||
        (b >= B_PEND_LO && b <= B_PEND_HI); // RULE13 RULE15
endfunction

function automatic logic sub_ok(input logic [7:0] s);
    sub_ok = s inside {SUB_RDVAL, SUB_RDTHR, SUB_WRVAL, SUB_RDLOG, SUB_WRLOG, SUB_ENA,
        SUB_DIS, SUB_STAT};
endfunction

// millisecond time base, free to wrap
always_ff @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        pre_r <= 32'h0000_0000;
        ms_r <= 32'h0000_0000;
    end
    else if (pre_r == 32'(MS_CYC - 1))
    begin
        pre_r <= 32'h0000_0000;
        ms_r <= ms_r + 32'h0000_0001; // RULE2
    end
    else
    begin
        pre_r <= pre_r + 32'h0000_0001;
    end
end

// five history slots, hwp_r is the oldest
always_ff @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        hwp_r <= 3'h0;
        dstate_r <= 4'h0;
    end
    else if (i_cmd_wr)
    begin
        hwp_r <= (hwp_r == 3'(N_ERR - 1)) ? 3'h0 : hwp_r + 3'h1;
        dstate_r <= i_dev_state; // RULE5
    end
end

always_ff @(posedge i_clk)
begin
    if (i_cmd_wr)
    begin
        hist[hb + 0] <= i_tf_devctl; // RULE1
        hist[hb + 1] <= i_tf_feat;
        hist[hb + 2] <= i_tf_count;
        hist[hb + 3] <= i_tf_lba_lo;
        hist[hb + 4] <= i_tf_lba_mid;
        hist[hb + 5] <= i_tf_lba_hi;
        hist[hb + 6] <= i_tf_dev;
        hist[hb + 7] <= i_tf_cmd;
        for (int i = 0; i < 4; i++)
        begin
            hist[hb + 8 + i] <= ms_r[8*i +: 8]; // RULE2 RULE16
        end
    end
end

// completion and self-test snapshots; a second event before the copy overwrites the first
always_ff @(posedge i_clk)
begin
    if (err_evt)
    begin
        errb[0] <= 8'h00; // RULE3
        errb[1] <= i_cmp_error;
        errb[2] <= i_cmp_count;
        errb[3] <= i_cmp_lba_lo;
        errb[4] <= i_cmp_lba_mid;
        errb[5] <= i_cmp_lba_hi;
        errb[6] <= i_cmp_dev;
        errb[7] <= i_cmp_status;
        for (int i = 8; i < 27; i++)
        begin
            errb[i] <= (i < 12) ? ms_r[8*(i-8) +: 8] : 8'h00; // RULE4
        end
        errb[27] <= {STATE_HI_NIB, dstate_r}; // RULE5 RULE6
        errb[28] <= i_life[7:0]; // RULE7 RULE16
        errb[29] <= i_life[15:8];
    end
    if (i_st_done)
    begin
        stb[0] <= i_st_num; // RULE9
        stb[1] <= i_st_stat;
        stb[2] <= i_life[7:0];
        stb[3] <= i_life[15:8];
        stb[4] <= i_st_chk;
        for (int i = 0; i < 4; i++)
        begin
            stb[5 + i] <= i_st_lba[8*i +: 8]; // RULE16
        end
        for (int i = 9; i < ST_DESC_LEN; i++)
        begin
            stb[i] <= 8'h00;
        end
    end
end

// set wins over the start that consumes it
always_ff @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        err_pend_r <= 1'b0;
        st_pend_r <= 1'b0;
    end
    else
    begin
        err_pend_r <= err_evt | (err_pend_r & ~start_err);
        st_pend_r <= i_st_done | (st_pend_r & ~start_st);
    end
end

always_ff @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        prog_r <= 80'h0;
    end
    else
    begin
        prog_r <= {i_st_cur_span, i_st_cur_lba}; // RULE14
    end
end

// pointers, counter and sequencer
always_ff @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        seq_r <= S_IDLE;
        k_r <= 7'h00;
        eptr_r <= 3'(N_ERR); // RULE22
        ecnt_r <= 16'h0000;
        stp_r <= 5'h00; // RULE11
    end
    else
    begin
        case (seq_r)
            S_IDLE:
            begin
                k_r <= 7'h00;
                if (start_err)
                begin
                    eptr_r <= (eptr_r == 3'(N_ERR)) ? 3'h1 : eptr_r + 3'h1; // RULE22 RULE24
                    if (ecnt_r != 16'hFFFF)
                    begin
                        ecnt_r <= ecnt_r + 16'h0001; // RULE23
                    end
                    seq_r <= S_ERR;
                end
                else if (start_st)
                begin
                    stp_r <= (stp_r == 5'(N_ST)) ? 5'h01 : stp_r + 5'h01; // RULE10 RULE11
                    seq_r <= S_ST;
                end
                else if (start_wbw)
                begin
                    seq_r <= S_WBW;
                end
            end
            S_ERR:
            begin
                k_r <= (k_r == 7'(ERR_ENT_LEN - 1)) ? 7'h00 : k_r + 7'h01;
                if (k_r == 7'(ERR_ENT_LEN - 1))
                begin
                    seq_r <= S_EHDR;
                end
            end
            S_EHDR:
            begin
                k_r <= k_r + 7'h01;
                if (k_r == 7'h02)
                begin
                    seq_r <= S_IDLE;
                end
            end
            S_ST:
            begin
                k_r <= k_r + 7'h01;
                if (k_r == 7'(ST_DESC_LEN - 1))
                begin
                    seq_r <= S_SPTR;
                end
            end
            S_SPTR:
            begin
                seq_r <= S_IDLE;
            end
            S_WBW:
            begin
                k_r <= k_r + 7'h01;
                if (k_r == 7'h03)
                begin
                    seq_r <= S_IDLE;
                end
            end
            default:
            begin
                seq_r <= S_IDLE;
            end
        endcase
    end
end

// one byte written per cycle
always_comb
begin
    int kk;
    int slot;
    int b;
    kk = int'(k_r);
    slot = (int'(hwp_r) + kk / CMD_LEN) % N_ERR;
    b = int'({i_wb_adr[8:2], k_r[1:0]});
    we = 1'b0;
    wa = 11'h000;
    wd = 8'h00;
    case (seq_r)
        S_ERR:
        begin
            we = 1'b1;
            wa = 11'(B_EBASE + (int'(eptr_r) - 1) * ERR_ENT_LEN + kk); // RULE24
            wd = (kk < CMD_BYTES) ? hist[slot * CMD_LEN + kk % CMD_LEN] :
                errb[kk - CMD_BYTES];
        end
        S_EHDR:
        begin
            we = 1'b1;
            wa = (k_r == 7'h00) ? 11'(B_EPTR) : 11'(B_ECNT + kk - 1);
            wd = (k_r == 7'h00) ? {5'h00, eptr_r} : // RULE22
                ((k_r == 7'h01) ? ecnt_r[7:0] : ecnt_r[15:8]); // RULE16
        end
        S_ST:
        begin
            we = 1'b1;
            wa = 11'(SECT + B_STBASE + (int'(stp_r) - 1) * ST_DESC_LEN + kk); // RULE8
            wd = stb[kk];
        end
        S_SPTR:
        begin
            we = 1'b1;
            wa = 11'(SECT + B_STPTR);
            wd = {3'h0, stp_r}; // RULE11
        end
        S_WBW:
        begin
            we = i_wb_sel[k_r[1:0]] & host_writable(b); // RULE13 RULE15
            wa = {LOG_SEL, 9'(b)};
            wd = i_wb_dat[8*k_r[1:0] +: 8];
        end
        default:
        begin
            we = 1'b0;
        end
    endcase
end

// running sums keep the checksum ready
always_ff @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        for (int i = 0; i < 3*SECT; i++)
        begin
            mem[i] <= 8'h00;
        end
        mem[0] <= ERR_LOG_VER;
        mem[SECT] <= ST_REV;
        mem[2*SECT] <= SEL_REV;
        sum_r[0] <= ERR_LOG_VER;
        sum_r[1] <= ST_REV;
        sum_r[2] <= SEL_REV;
    end
    else if (we)
    begin
        mem[wa] <= wd;
        sum_r[wa[10:9]] <= sum_r[wa[10:9]] + wd - mem[wa]; // RULE12
    end
end

always_comb
begin
    prog_sum = 8'h00;
    for (int i = 0; i < 10; i++)
    begin
        prog_sum = prog_sum + prog_r[8*i +: 8];
    end
end

// sector read: progress overlaid
always_comb
begin
    int b;
    logic [1:0] lg;
    b = 0;
    lg = i_wb_adr[10:9];
    rd_word = RD_UNMAPPED;
    if (i_wb_adr[11:9] <= {1'b0, LOG_SEL})
    begin
        for (int i = 0; i < 4; i++)
        begin
            b = int'({i_wb_adr[8:2], 2'(i)});
            if (b == B_CSUM)
            begin
                rd_word[8*i +: 8] = 8'h00 - sum_r[lg] -
                    ((lg == LOG_SEL) ? prog_sum : 8'h00); // RULE12
            end
            else if (lg == LOG_SEL && b >= B_PROG_LO && b <= B_PROG_HI)
            begin
                rd_word[8*i +: 8] = prog_r[8*(b - B_PROG_LO) +: 8]; // RULE14 RULE16
            end
            else
            begin
                rd_word[8*i +: 8] = mem[{lg, 9'(b)}];
            end
        end
    end
    else if (i_wb_adr[11:2] == A_CTRL[11:2])
    begin
        rd_word = {31'h0, hm_en_r};
    end
    else if (i_wb_adr[11:2] == A_STAT[11:2])
    begin
        rd_word = {ecnt_r, 14'h0, (seq_r != S_IDLE), hm_en_r};
    end
    else if (i_wb_adr[11:2] == A_MS[11:2])
    begin
        rd_word = ms_r;
    end
end

always_ff @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        ack_r <= 1'b0;
        rdat_r <= 32'h0000_0000;
    end
    else
    begin
        ack_r <= (req & ~sel_wr) | ((seq_r == S_WBW) & (k_r == 7'h03));
        if (req & ~i_wb_we)
        begin
            rdat_r <= rd_word;
        end
    end
end

// health command check, in order of precedence
always_ff @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        hm_en_r <= HM_EN_RST;
        hm_done_r <= 1'b0;
        hm_sts_r <= 8'h00;
        hm_err_r <= 8'h00;
    end
    else
    begin
        hm_done_r <= 1'b0;
        if (req & i_wb_we & i_wb_sel[0] & (i_wb_adr[11:2] == A_CTRL[11:2]))
        begin
            hm_en_r <= i_wb_dat[0];
        end
        if (i_cmd_wr && i_tf_cmd == HM_CMD)
        begin
            hm_done_r <= 1'b1;
            hm_sts_r <= STS_FAIL;
            if (i_tf_lba_mid != KEY_MID || i_tf_lba_hi != KEY_HI || // RULE17
                !sub_ok(i_tf_feat) || // RULE18
                (!hm_en_r && i_tf_feat != SUB_ENA)) // RULE19
            begin
                hm_err_r <= ER_ABRT;
            end
            else if ((i_tf_feat == SUB_RDVAL || i_tf_feat == SUB_RDTHR) && i_tbl_rd_fail)
            begin
                hm_err_r <= ER_TBL_RD; // RULE20
            end
            else if (i_tf_feat == SUB_WRVAL && i_tbl_wr_fail)
            begin
                hm_err_r <= ER_TBL_WR; // RULE21
            end
            else
            begin
                hm_sts_r <= STS_OK;
                hm_err_r <= ER_NONE;
                if (i_tf_feat == SUB_ENA)
                begin
                    hm_en_r <= 1'b1;
                end
                else if (i_tf_feat == SUB_DIS)
                begin
                    hm_en_r <= 1'b0;
                end
            end
        end
    end
end

endmodule

// ===== sim/smart_log_host.sv
`timescale 1ns/10ps
module smart_log_host (
    input wire logic i_clk,
    output logic o_cmd_wr,
    output logic [63:0] o_tf,
    output logic o_cmp,
    output logic [55:0] o_cf
);
    initial
    begin
        o_cmd_wr = 1'b0;
        o_tf = 64'h0;
        o_cmp = 1'b0;
        o_cf = 56'h0;
    end
    task automatic issue(input logic [63:0] tf);
        @(posedge i_clk);
        o_tf <= tf;
        o_cmd_wr <= 1'b1;
        @(posedge i_clk);
        o_tf <= ~tf;
        o_cmd_wr <= 1'b0;
    endtask
    task automatic complete(input logic [55:0] cf);
        @(posedge i_clk);
        o_cf <= cf;
        o_cmp <= 1'b1;
        @(posedge i_clk);
        o_cf <= ~cf;
        o_cmp <= 1'b0;
    endtask
endmodule

// ===== sim/smart_log_recorder_bench.sv
`timescale 1ns/10ps
module smart_log_recorder_bench
    import smart_log_pkg::*;
;
    logic i_clk, i_rst_n, i_wb_cyc, i_wb_we, o_wb_ack, i_cmd_wr, i_cmp, i_st_done;
    logic i_tbl_rd_fail, i_tbl_wr_fail, o_hm_done, o_hm_en;
    logic [3:0] i_wb_sel, i_dev_state;
    logic [11:0] i_wb_adr;
    logic [31:0] i_wb_dat, o_wb_dat, q, m, ms;
    logic [7:0] o_hm_status, o_hm_error, b, sum;
    logic [15:0] i_life, i_st_cur_span;
    logic [63:0] tf, i_st_cur_lba;
    logic [55:0] cf, st;
    int num_errors, n_tests;
    int rt[5] = '{32'h0001, 32'h0100, 32'h20001, 32'h3FC00, 32'h40001};
    logic [47:0] hm_t[11] = '{48'hD0_00_C2_10_51_04, 48'hD2_4F_C2_10_51_04,
        48'hD0_4F_C2_11_51_10, 48'hD1_4F_C2_11_51_10, 48'hD3_4F_C2_12_51_40,
        48'hD5_4F_C2_10_50_00, 48'hD6_4F_C2_10_50_00, 48'hDA_4F_C2_10_50_00,
        48'hD9_4F_C2_00_50_00, 48'hD0_4F_C2_01_51_04, 48'hD8_4F_C2_10_50_00};
    localparam logic [63:0] TF_E = 64'h25E0554433221108;
    localparam logic [63:0] EV_E = 64'h51E1040302014000;
    localparam logic [71:0] ST_E = 72'h12345678_07_A5C3_F1_16;
    smart_log_recorder #(.MS_CYC(10)) u_smart_log_recorder (.i_clk, .i_rst_n, .i_wb_cyc,
        .i_wb_stb(i_wb_cyc), .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
        .i_cmd_wr, .i_tf_devctl(tf[7:0]), .i_tf_feat(tf[15:8]), .i_tf_count(tf[23:16]),
        .i_tf_lba_lo(tf[31:24]), .i_tf_lba_mid(tf[39:32]), .i_tf_lba_hi(tf[47:40]),
        .i_tf_dev(tf[55:48]), .i_tf_cmd(tf[63:56]), .i_dev_state, .i_cmp,
        .i_cmp_error(cf[7:0]), .i_cmp_count(cf[15:8]), .i_cmp_lba_lo(cf[23:16]),
        .i_cmp_lba_mid(cf[31:24]), .i_cmp_lba_hi(cf[39:32]), .i_cmp_dev(cf[47:40]),
        .i_cmp_status(cf[55:48]), .i_life, .i_st_done, .i_st_num(st[7:0]),
        .i_st_stat(st[15:8]), .i_st_chk(st[23:16]), .i_st_lba(st[55:24]), .i_st_cur_lba,
        .i_st_cur_span, .i_tbl_rd_fail, .i_tbl_wr_fail, .o_hm_done, .o_hm_status,
        .o_hm_error, .o_hm_en);
    smart_log_host u_host (.i_clk, .o_cmd_wr(i_cmd_wr), .o_tf(tf), .o_cmp(i_cmp), .o_cf(cf));
    task automatic chk(input string w, input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_wb_ack !== 1'b1 && n < 400);
        num_errors += int'(n >= 400);
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
    endtask
    task automatic rb(input int a);
        wb(1'b0, 12'(a) & 12'hFFC, 32'h0);
        b = q[8 * (a % 4) +: 8];
    endtask
    task automatic settle;
        int n;
        n = 0;
        q = 32'h2;
        while (q[1] !== 1'b0 && n < 200)
        begin
            wb(1'b0, A_STAT, 32'h0);
            n++;
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (40000) @(posedge i_clk);
        num_errors++;
        close_out();
    end
    initial
    begin
        {i_rst_n, i_wb_cyc, i_wb_we, i_st_done, i_tbl_rd_fail, i_tbl_wr_fail} = 6'h0;
        i_wb_sel = 4'hF;
        i_wb_adr = 12'h0;
        i_wb_dat = 32'h0;
        i_dev_state = 4'h3;
        i_life = 16'hA5C3;
        st = 56'h0;
        i_st_cur_lba = 64'h0102030405060708;
        i_st_cur_span = 16'h0003;
        num_errors = 0;
        n_tests = 0;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        foreach (rt[i])
        begin
            rb(rt[i] >> 8);
            chk("after reset", b, rt[i][7:0]);
        end
        wb(1'b0, 12'h700, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b1, 12'h004, 32'hFFFFFFFF);
        rb(4);
        chk("log write ignored", b, 8'h00);
        foreach (hm_t[i])
        begin
            @(posedge i_clk);
            i_tbl_rd_fail <= hm_t[i][16];
            i_tbl_wr_fail <= hm_t[i][17];
            u_host.issue({HM_CMD, 8'hA0, hm_t[i][31:24], hm_t[i][39:32], 16'h0,
                hm_t[i][47:40], 8'h0});
            @(negedge i_clk);
            chk("done", o_hm_done, 1'b1);
            chk("answer", {o_hm_status, o_hm_error}, hm_t[i][15:0]);
            chk("enable", o_hm_en, hm_t[i][20]);
        end
        wb(1'b0, A_MS, 32'h0);
        m = q;
        u_host.issue(TF_E);
        u_host.complete(56'h51E10403020140);
        settle();
        for (int i = 0; i < 8; i++)
        begin
            rb(50 + i);
            chk("command", b, TF_E[8 * i +: 8]);
            rb(62 + i);
            chk("error", b, EV_E[8 * i +: 8]);
        end
        for (int i = 0; i < 4; i++)
        begin
            rb(58 + i);
            ms[8 * i +: 8] = b;
        end
        chk("stamp", 32'(ms - m < 3), 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            rb(89 + i);
            chk("state life", b, 24'hA5C303 >> (8 * i) & 24'hFF);
        end
        for (int k = 1; k <= 6; k++)
        begin
            if (k > 1)
                u_host.complete({8'h51, 40'h0, 8'(k)});
            settle();
            rb(1);
            chk("pointer", b, 8'((k - 1) % 5 + 1));
            rb(63 + 90 * ((k - 1) % 5));
            chk("entry", b, (k > 1) ? 8'(k) : 8'h40);
            rb(B_ECNT);
            chk("count", b, 8'(k));
        end
        for (int k = 1; k <= 22; k++)
        begin
            @(posedge i_clk);
            st <= {32'h12345678, 8'h07, 8'hF1, 8'(k)};
            i_st_done <= 1'b1;
            @(posedge i_clk);
            i_st_done <= 1'b0;
            settle();
            rb(12'h3FC);
            chk("st pointer", b, 8'((k - 1) % 21 + 1));
        end
        for (int i = 0; i < 9; i++)
        begin
            rb(12'h202 + i);
            chk("descriptor", b, ST_E[8 * i +: 8]);
        end
        wb(1'b1, 12'h404, 32'hDDCCBBAA);
        wb(1'b0, 12'h404, 32'h0);
        chk("span", q, 32'hDDCCBBAA);
        wb(1'b1, 12'h5EC, 32'hFFFFFFFF);
        wb(1'b0, 12'h5EC, 32'h0);
        chk("current lba", q, 32'h05060708);
        wb(1'b1, 12'h5F4, 32'h5A5AFFFF);
        wb(1'b0, 12'h5F4, 32'h0);
        chk("flags", q, 32'h5A5A0003);
        i_wb_sel <= 4'h3;
        wb(1'b1, 12'h5FC, 32'hFFFF1234);
        i_wb_sel <= 4'hF;
        wb(1'b0, 12'h5FC, 32'h0);
        chk("pending", q[15:0], 16'h1234);
        for (int s = 0; s < 3; s++)
        begin
            sum = 8'h00;
            for (int w = 0; w < 128; w++)
            begin
                wb(1'b0, 12'(s * 512 + w * 4), 32'h0);
                sum = sum + q[7:0] + q[15:8] + q[23:16] + q[31:24];
            end
            chk("checksum", sum, 8'h00);
        end
        close_out();
    end
endmodule

// ===== sim/smart_log_recorder_monitor.sv
`timescale 1ns/10ps
module smart_log_recorder_monitor
    import smart_log_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_tf_feat,
    input wire logic [7:0] i_tf_lba_mid,
    input wire logic [7:0] i_tf_lba_hi,
    input wire logic [7:0] i_tf_cmd,
    input wire logic i_tbl_rd_fail,
    input wire logic i_tbl_wr_fail,
    input wire logic o_hm_done,
    input wire logic [7:0] o_hm_status,
    input wire logic [7:0] o_hm_error,
    input wire logic o_hm_en
);
    logic hm;
    logic key;
    logic sub_ok;
    assign hm = i_cmd_wr && i_tf_cmd == HM_CMD;
    assign key = i_tf_lba_mid == KEY_MID && i_tf_lba_hi == KEY_HI;
    assign sub_ok = i_tf_feat inside {SUB_RDVAL, SUB_RDTHR, SUB_WRVAL, SUB_RDLOG, SUB_WRLOG,
        SUB_ENA, SUB_DIS, SUB_STAT};
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_abort;
        o_hm_done && o_hm_status == STS_FAIL && o_hm_error == ER_ABRT;
    endsequence
    sequence s_pass;
        o_hm_done && o_hm_status == STS_OK && o_hm_error == ER_NONE;
    endsequence
    chk_key_missing: assert property (hm && !key |=> s_abort)
        else $error("no key but no abort");
    chk_bad_subcmd: assert property (hm && key && !sub_ok |=> s_abort)
        else $error("bad subcommand not aborted");
    chk_disabled_sub: assert property (hm && key && sub_ok && !o_hm_en
        && i_tf_feat != SUB_ENA |=> s_abort) else $error("disabled state not aborted");
    chk_table_read: assert property (hm && key && o_hm_en && i_tbl_rd_fail
        && (i_tf_feat == SUB_RDVAL || i_tf_feat == SUB_RDTHR)
        |=> o_hm_done && o_hm_status == STS_FAIL && o_hm_error == ER_TBL_RD)
        else $error("table read failure wrong answer");
    chk_table_write: assert property (hm && key && o_hm_en && i_tbl_wr_fail
        && i_tf_feat == SUB_WRVAL
        |=> o_hm_done && o_hm_status == STS_FAIL && o_hm_error == ER_TBL_WR)
        else $error("table write failure wrong answer");
    chk_enable_sub: assert property (hm && key && i_tf_feat == SUB_ENA |=> s_pass ##1 o_hm_en)
        else $error("enable subcommand not honoured");
    chk_done_cause: assert property (o_hm_done |-> $past(hm))
        else $error("done without health command");
    chk_result_hold: assert property (!o_hm_done |-> $stable(o_hm_status)
        && $stable(o_hm_error)) else $error("answer changed without command");
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
endmodule
bind smart_log_recorder smart_log_recorder_monitor u_monitor (.i_clk, .i_rst_n, .i_wb_cyc,
    .i_wb_stb, .o_wb_ack, .i_cmd_wr, .i_tf_feat, .i_tf_lba_mid, .i_tf_lba_hi, .i_tf_cmd,
    .i_tbl_rd_fail, .i_tbl_wr_fail, .o_hm_done, .o_hm_status, .o_hm_error, .o_hm_en);
